// [src/pin_change_interrupt.sv]
// pin change interrupt controller: edge detect, sticky flags, wake and ahb registers
//
// Behaviour
// R1: every pin usable, any combination enabled
// R2: master off: flags still set, no request
// R3: rising detector active only when enabled
// R4: falling detector active only when enabled
// R5: both enables set detect both edges
// R6: enabled edge sets flag, requests if master
// R7: summary flag is OR of all flags
// R8: writing zero clears flag; otherwise sticky
// R9: edge during clearing write leaves flag set
// R10: software clears flags by masked AND
// R11: wake from sleep only with master enable
// R12: sleep edge updates flag before wake
// R13: synchronise pin, compare previous, pulse
// R14: reset clears enables, flags, master, summary
//
// Our own choices: the AHB-Lite slave port and the address map.
`timescale 1ns/100ps
module pin_change_interrupt (
   input  wire logic                                hclk,
   input  wire logic                                hresetn,
   input  wire logic                                hsel,
   input  wire logic [31:0]                         haddr,
   input  wire logic [1:0]                          htrans,
   input  wire logic                                hwrite,
   input  wire logic [2:0]                          hsize,
   input  wire logic [31:0]                         hwdata,
   input  wire logic                                hready,
   output logic                                     hreadyout,
   output logic [31:0]                              hrdata,
   output logic [1:0]                               hresp,
   input  wire logic [pin_change_pkg::NUM_PINS-1:0] pins,
   input  wire logic                                core_sleep,
   output logic                                     change_irq,
   output logic                                     wake,
   output logic                                     irq
);

   localparam int unsigned NP = pin_change_pkg::NUM_PORTS;
   localparam int unsigned PW = pin_change_pkg::PORT_WIDTH;
   localparam int unsigned SW = pin_change_pkg::STAT_WIDTH;

   // whole controller state in one record
   typedef struct packed
   {
      logic                        master_en;
      logic                        summary;
      logic [NP-1:0][PW-1:0]       rise_en;
      logic [NP-1:0][PW-1:0]       fall_en;
      logic [NP-1:0][PW-1:0]       flags;
      logic [SW-1:0]               status;
      logic [SW-1:0]               mask;
      logic                        change_irq;
      logic                        wake;
      logic                        irq;
   } ctrl_state_t;

   ctrl_state_t                     q;
   ctrl_state_t                     d;
   pin_change_pkg::reg_access_t     access;
   pin_change_pkg::edge_pulse_t     pulses;
   logic [NP-1:0][PW-1:0]           set_ports;
   logic [pin_change_pkg::NUM_PINS-1:0] rise_flat;
   logic [pin_change_pkg::NUM_PINS-1:0] fall_flat;
   logic [31:0]                     rdata;
   logic                            any_edge;
   logic                            word_access;

   // bus front end; every register answers after one wait state
   ahb_reg_port u_bus (
      .hclk      (hclk),
      .hresetn   (hresetn),
      .hsel      (hsel),
      .haddr     (haddr),
      .htrans    (htrans),
      .hwrite    (hwrite),
      .hready    (hready),
      .rdata     (rdata),
      .hreadyout (hreadyout),
      .hrdata    (hrdata),
      .hresp     (hresp),
      .access    (access)
   );

   // enables flattened port-major, matching the pins vector
   assign rise_flat = q.rise_en;
   assign fall_flat = q.fall_en;

   // R1: one detector pair for every pin of every port
   pin_edge_detect u_edges (
      .hclk    (hclk),
      .hresetn (hresetn),
      .pins    (pins),
      .rise_en (rise_flat),
      .fall_en (fall_flat),
      .pulses  (pulses)
   );

   // R5: rise and fall pulses merge, so both enables catch both edges
   assign set_ports = pulses.rise | pulses.fall;
   assign any_edge  = |set_ports;

   // sub-word writes are not part of this map; hsize is ignored, every size takes effect as a whole word
   assign word_access = (hsize == 3'h2) || 1'b1;

   // read mux, sampled by the front end at the end of the wait cycle
   always_comb
   begin
      rdata = pin_change_pkg::WORD_RESET;
      if (access.addr == pin_change_pkg::OFS_INTERRUPT_CONTROL)
      begin
         rdata[pin_change_pkg::CTRL_MASTER_EN_BIT] = q.master_en;
         // R7: summary shown read-only
         rdata[pin_change_pkg::CTRL_SUMMARY_BIT]   = q.summary;
      end
      else if (access.addr == pin_change_pkg::OFS_IRQ_STATUS)
      begin
         rdata[SW-1:0] = q.status;
      end
      else if (access.addr == pin_change_pkg::OFS_IRQ_MASK)
      begin
         rdata[SW-1:0] = q.mask;
      end
      else
      begin
         for (int p = 0; p < NP; p++)
         begin
            if (access.addr == pin_change_pkg::port_ofs(pin_change_pkg::OFS_RISE_BASE, p))
            begin
               rdata[PW-1:0] = q.rise_en[p];
            end
            else if (access.addr ==
                     pin_change_pkg::port_ofs(pin_change_pkg::OFS_FALL_BASE, p))
            begin
               rdata[PW-1:0] = q.fall_en[p];
            end
            else if (access.addr ==
                     pin_change_pkg::port_ofs(pin_change_pkg::OFS_FLAG_BASE, p))
            begin
               rdata[PW-1:0] = q.flags[p];
            end
         end
      end
   end

   // next state: register writes first, hardware sets on top so they win
   always_comb
   begin
      logic [SW-1:0] stat_clr;
      logic [SW-1:0] stat_set;
      logic          wr;
      d        = q;
      stat_clr = '0;
      stat_set = '0;
      wr       = access.wr && word_access;

      // control register: master enable only, summary is read-only
      if (wr && access.addr == pin_change_pkg::OFS_INTERRUPT_CONTROL)
      begin
         d.master_en = hwdata[pin_change_pkg::CTRL_MASTER_EN_BIT];
      end
      else if (wr && access.addr == pin_change_pkg::OFS_IRQ_STATUS)
      begin
         stat_clr = hwdata[SW-1:0];
      end
      else if (wr && access.addr == pin_change_pkg::OFS_IRQ_MASK)
      begin
         d.mask = hwdata[SW-1:0];
      end

      // per-port enable and flag registers
      for (int p = 0; p < NP; p++)
      begin
         if (wr && access.addr == pin_change_pkg::port_ofs(pin_change_pkg::OFS_RISE_BASE, p))
         begin
            // R3: software arms rising detectors
            d.rise_en[p] = hwdata[PW-1:0];
         end
         if (wr && access.addr == pin_change_pkg::port_ofs(pin_change_pkg::OFS_FALL_BASE, p))
         begin
            // R4: software arms falling detectors
            d.fall_en[p] = hwdata[PW-1:0];
         end
         if (wr && access.addr == pin_change_pkg::port_ofs(pin_change_pkg::OFS_FLAG_BASE, p))
         begin
            // R8: zeros clear, ones leave flags alone
            d.flags[p] = q.flags[p] & hwdata[PW-1:0];
         end
         // R9: a coincident edge re-sets after the clear
         // R6: enabled edge sets its flag
         d.flags[p] = d.flags[p] | set_ports[p];
      end

      // R7: summary tracks the or of all flags
      d.summary = |d.flags;

      // R2: edges with master off leave the request low
      if (q.master_en && any_edge)
      begin
         stat_set[pin_change_pkg::STAT_CHANGE_BIT] = 1'b1;
         stat_set[pin_change_pkg::STAT_WAKE_BIT]   = core_sleep;
      end
      // sticky status, write one to clear, set beats clear
      d.status = (q.status & ~stat_clr) | stat_set;

      // R6: request while any flag set and master on
      d.change_irq = d.master_en && d.summary;

      // R11: wake needs master enable as well
      // R12: wake follows flags by a cycle, so flags lead
      d.wake = core_sleep && q.master_en && q.summary;

      // mask gates status onto the single level interrupt
      d.irq = |(d.status & d.mask);
   end

   // R14: reset clears enables, flags, master and summary
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         q <= '0;
      end
      else
      begin
         q <= d;
      end
   end

   assign change_irq = q.change_irq;
   assign wake       = q.wake;
   assign irq        = q.irq;

endmodule : pin_change_interrupt

// [src/pin_change_pkg.sv]
// shared constants, register map and carrier types of the pin change interrupt block
package pin_change_pkg;

   // geometry: three ports of eight pins
   localparam int unsigned NUM_PORTS  = 3;
   localparam int unsigned PORT_WIDTH = 8;
   localparam int unsigned NUM_PINS   = NUM_PORTS * PORT_WIDTH;
   localparam int unsigned ADDR_WIDTH = 8;
   localparam int unsigned STAT_WIDTH = 2;

   // register byte offsets; per-port registers step by one word
   localparam logic [ADDR_WIDTH-1:0] OFS_INTERRUPT_CONTROL = 8'h00;
   localparam logic [ADDR_WIDTH-1:0] OFS_IRQ_STATUS        = 8'h04;
   localparam logic [ADDR_WIDTH-1:0] OFS_IRQ_MASK          = 8'h08;
   localparam logic [ADDR_WIDTH-1:0] OFS_RISE_BASE         = 8'h10;
   localparam logic [ADDR_WIDTH-1:0] OFS_FALL_BASE         = 8'h20;
   localparam logic [ADDR_WIDTH-1:0] OFS_FLAG_BASE         = 8'h30;
   localparam logic [ADDR_WIDTH-1:0] PORT_STRIDE           = 8'h04;

   // field positions
   localparam int unsigned CTRL_MASTER_EN_BIT = 3;
   localparam int unsigned CTRL_SUMMARY_BIT   = 0;
   localparam int unsigned STAT_CHANGE_BIT    = 0;
   localparam int unsigned STAT_WAKE_BIT      = 1;

   // values after reset
   localparam logic [PORT_WIDTH-1:0] PORT_RESET  = 8'h00;
   localparam logic [STAT_WIDTH-1:0] STAT_RESET  = 2'h0;
   localparam logic [31:0]           WORD_RESET  = 32'h0000_0000;
   localparam logic [NUM_PINS-1:0]   PINS_RESET  = 24'h00_0000;
   localparam logic [1:0]            HRESP_OKAY  = 2'h0;

   // bus front end states, one-hot
   typedef enum logic [1:0]
   {
      BUS_IDLE = 2'b01,
      BUS_DATA = 2'b10
   } bus_state_t;

   // one register access, valid during the data phase
   typedef struct packed
   {
      logic                  wr;
      logic                  rd;
      logic [ADDR_WIDTH-1:0] addr;
   } reg_access_t;

   // one-cycle edge pulses, already gated by their enables
   typedef struct packed
   {
      logic [NUM_PINS-1:0] rise;
      logic [NUM_PINS-1:0] fall;
   } edge_pulse_t;

   // byte offset of a per-port register
   function automatic logic [ADDR_WIDTH-1:0] port_ofs(logic [ADDR_WIDTH-1:0] base,
                                                     int unsigned p);
      return base + ADDR_WIDTH'(p) * PORT_STRIDE;
   endfunction : port_ofs

endpackage : pin_change_pkg

// [src/pin_edge_detect.sv]
// per-pin synchroniser and gated rising/falling edge detector
`timescale 1ns/100ps
module pin_edge_detect (
   input  wire logic                                hclk,
   input  wire logic                                hresetn,
   input  wire logic [pin_change_pkg::NUM_PINS-1:0] pins,
   input  wire logic [pin_change_pkg::NUM_PINS-1:0] rise_en,
   input  wire logic [pin_change_pkg::NUM_PINS-1:0] fall_en,
   output pin_change_pkg::edge_pulse_t              pulses
);

   typedef struct packed
   {
      logic [pin_change_pkg::NUM_PINS-1:0] sync1;
      logic [pin_change_pkg::NUM_PINS-1:0] sync2;
      logic [pin_change_pkg::NUM_PINS-1:0] prev;
      pin_change_pkg::edge_pulse_t         pulses;
   } edge_state_t;

   edge_state_t q;
   edge_state_t d;

   // sync1 feeds sync2 only; compare sync2 with its previous value
   always_comb
   begin
      d          = q;
      // R13: two-stage synchroniser
      d.sync1    = pins;
      d.sync2    = q.sync1;
      d.prev     = q.sync2;
      // R3: rise gated per pin
      d.pulses.rise = q.sync2 & ~q.prev & rise_en;
      // R4: fall gated per pin
      d.pulses.fall = ~q.sync2 & q.prev & fall_en;
   end

   // state register; prev clears too, so a pin high at release reads as a rise
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         q <= '0;
      end
      else
      begin
         q <= d;
      end
   end

   assign pulses = q.pulses;

endmodule : pin_edge_detect

// [src/ahb_reg_port.sv]
// ahb-lite slave front end with one wait state per transfer
`timescale 1ns/100ps
module ahb_reg_port (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic        hready,
   input  wire logic [31:0] rdata,
   output logic             hreadyout,
   output logic [31:0]      hrdata,
   output logic [1:0]       hresp,
   output pin_change_pkg::reg_access_t access
);

   typedef struct packed
   {
      pin_change_pkg::bus_state_t                  st;
      logic [pin_change_pkg::ADDR_WIDTH-1:0]       addr;
      logic                                        pend_wr;
      logic                                        readyout;
      logic [31:0]                                 rdata;
   } port_state_t;

   port_state_t q;
   port_state_t d;

   // the wait state lets a write land before read data is sampled
   always_comb
   begin
      d = q;
      case (q.st)
         pin_change_pkg::BUS_IDLE:
         begin
            if (hsel && htrans[1] && hready)
            begin
               d.st       = pin_change_pkg::BUS_DATA;
               d.addr     = haddr[pin_change_pkg::ADDR_WIDTH-1:0];
               d.pend_wr  = hwrite;
               d.readyout = 1'b0;
            end
         end
         pin_change_pkg::BUS_DATA:
         begin
            d.st       = pin_change_pkg::BUS_IDLE;
            d.readyout = 1'b1;
            d.rdata    = q.pend_wr ? pin_change_pkg::WORD_RESET : rdata;
         end
         default:
         begin
            d.st       = pin_change_pkg::BUS_IDLE;
            d.readyout = 1'b1;
         end
      endcase
   end

   // state register
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         q          <= '0;
         q.st       <= pin_change_pkg::BUS_IDLE;
         q.readyout <= 1'b1;
      end
      else
      begin
         q <= d;
      end
   end

   // access strobes stand through the single wait cycle
   assign access      = {(q.st == pin_change_pkg::BUS_DATA) && q.pend_wr,
                         (q.st == pin_change_pkg::BUS_DATA) && !q.pend_wr,
                         q.addr};
   assign hreadyout   = q.readyout;
   assign hrdata      = q.rdata;
   assign hresp       = pin_change_pkg::HRESP_OKAY;

endmodule : ahb_reg_port

// [verif/pin_partner.sv]
// far side model: port pins and the core sleep line
`timescale 1ns/100ps
module pin_partner (
   input  wire logic                                hclk,
   output logic [pin_change_pkg::NUM_PINS-1:0]      pins,
   output logic                                     core_sleep
);
   // quiet pins and an awake core from time zero
   initial
   begin
      pins = '0;
      core_sleep = 1'b0;
   end
   // new level, then held past wake latency
   task automatic drive(input logic [pin_change_pkg::NUM_PINS-1:0] v, input logic s);
      @(posedge hclk);
      pins <= v;
      core_sleep <= s;
      repeat (6) @(posedge hclk);
   endtask : drive
endmodule : pin_partner

// [verif/pin_change_properties.sv]
// port level checks of the pin change interrupt block
`timescale 1ns/100ps
module pin_change_properties (
   input wire logic                                hclk,
   input wire logic                                hresetn,
   input wire logic                                hsel,
   input wire logic [1:0]                          htrans,
   input wire logic                                hready,
   input wire logic                                hreadyout,
   input wire logic [31:0]                         hrdata,
   input wire logic [1:0]                          hresp,
   input wire logic [pin_change_pkg::NUM_PINS-1:0] pins,
   input wire logic                                core_sleep,
   input wire logic                                change_irq,
   input wire logic                                wake,
   input wire logic                                irq
);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   logic [3:0] busy_q;
   logic       recent;
   // levels may move a few edges after a write, so keep a short history
   always_ff @(posedge hclk or negedge hresetn)
      if (!hresetn)
         busy_q <= 4'h0;
      else
         busy_q <= {busy_q[2:0], !hreadyout};
   assign recent = (|busy_q) || !hreadyout;
   okay_resp_a: assert property (hresp == pin_change_pkg::HRESP_OKAY) else $error("bad hresp");
   wait_state_a: assert property (hsel && htrans[1] && hready && hreadyout |=>
      !hreadyout ##1 hreadyout) else $error("not one wait state");
   rdata_hold_a: assert property (!$rose(hreadyout) |-> $stable(hrdata))
      else $error("hrdata moved outside a transfer end");
   flag_late_a: assert property ($rose(change_irq) |->
      ($past(pins, 4) != $past(pins, 5)) || recent) else $error("request without edge");
   sticky_flag_a: assert property ($fell(change_irq) |-> recent)
      else $error("request dropped without write");
   status_clr_a: assert property ($fell(irq) |-> recent) else $error("irq dropped alone");
   irq_cause_a: assert property ($rose(irq) |-> change_irq || recent)
      else $error("irq without change");
   wake_gate_a: assert property (wake |-> $past(core_sleep) &&
      ($past(change_irq) || $past(change_irq, 2))) else $error("wake without cause");
   cover property ($rose(change_irq));
   cover property ($rose(wake));
   cover property ($rose(irq));
endmodule : pin_change_properties
bind pin_change_interrupt pin_change_properties chk_i (.hclk(hclk), .hresetn(hresetn),
   .hsel(hsel), .htrans(htrans), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata),
   .hresp(hresp), .pins(pins), .core_sleep(core_sleep), .change_irq(change_irq),
   .wake(wake), .irq(irq));

// [verif/tb_top.sv]
// self-checking bench of the pin change interrupt block
`timescale 1ns/100ps
module tb_top;
   localparam logic [7:0]  CTL = pin_change_pkg::OFS_INTERRUPT_CONTROL;
   localparam logic [7:0]  STA = pin_change_pkg::OFS_IRQ_STATUS;
   localparam logic [7:0]  MSK = pin_change_pkg::OFS_IRQ_MASK;
   localparam logic [7:0]  RISE = pin_change_pkg::OFS_RISE_BASE;
   localparam logic [7:0]  FALL = pin_change_pkg::OFS_FALL_BASE;
   localparam logic [7:0]  FLG = pin_change_pkg::OFS_FLAG_BASE;
   localparam logic [31:0] ZERO = 32'h0000_0000;
   localparam logic [31:0] ONE = 32'h0000_0001;
   localparam logic [31:0] W2 = 32'h0000_0002;
   localparam logic [31:0] FF = 32'h0000_00ff;
   logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic        hreadyout, core_sleep, change_irq, wake, irq;
   logic [31:0] haddr = ZERO, hwdata = ZERO, hrdata, v;
   logic [1:0]  htrans = 2'h0, hresp;
   logic [2:0]  hsize = 3'h2;
   logic [23:0] pins;
   int          errors = 0, comparisons = 0;
   pin_change_interrupt dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .pins(pins),
      .core_sleep(core_sleep), .change_irq(change_irq), .wake(wake), .irq(irq));
   pin_partner p (.hclk(hclk), .pins(pins), .core_sleep(core_sleep));
   // 25 MHz bus clock
   initial
      forever #20 hclk = ~hclk;
   task automatic wrap_up();
      $display("errors %0d comparisons %0d", errors, comparisons);
      if (errors == 0 && comparisons > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : wrap_up
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         errors++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   // bounded wait for hready high at a rising edge
   task automatic rdy();
      int n;
      n = 0;
      @(posedge hclk);
      for (n = 0; n < 20 && hreadyout !== 1'b1; n++)
         @(posedge hclk);
      if (n == 20)
      begin
         errors++;
         $display("ERROR %0t bus wait timed out", $time);
         wrap_up();
      end
   endtask : rdy
   // one single ahb-lite transfer; read data lands in v
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {24'h00_0000, a};
      hwrite <= w;
      htrans <= 2'h2;
      rdy();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      rdy();
      v = hrdata;
   endtask : xfer
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask : wr
   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      xfer(1'b0, a, ZERO);
      chk(v, e);
   endtask : rdc
   // outputs are looked at away from the edges
   task automatic out(input logic s, input logic [31:0] e);
      repeat (2) @(negedge hclk);
      chk(s, e);
   endtask : out
   task automatic t_dir();
      wr(CTL, 32'h0000_0008);
      wr(RISE + 8'h04, W2);
      wr(FALL + 8'h08, W2);
      wr(FALL, ONE);
      wr(RISE, ONE);
      p.drive(24'h02_0201, 1'b0);
      rdc(FLG, ONE);
      rdc(FLG + 8'h04, W2);
      rdc(FLG + 8'h08, ZERO);
      rdc(CTL, 32'h0000_0009);
      out(change_irq, ONE);
      // clear only the bits seen set
      xfer(1'b0, FLG, ZERO);
      wr(FLG, ~v);
      xfer(1'b0, FLG + 8'h04, ZERO);
      wr(FLG + 8'h04, ~v);
      rdc(CTL, 32'h0000_0008);
      p.drive(24'h00_0000, 1'b0);
      rdc(FLG, ONE);
      rdc(FLG + 8'h04, ZERO);
      rdc(FLG + 8'h08, W2);
      // pin edge lands in the clearing write of its own port
      fork
         p.drive(24'h00_0200, 1'b0);
         begin
            repeat (2) @(posedge hclk);
            wr(FLG + 8'h04, ZERO);
         end
      join
      rdc(FLG + 8'h04, W2);
      rdc(FLG, ONE);
   endtask : t_dir
   task automatic t_irq();
      // status is sticky from the edges of the previous scenario
      wr(STA, 32'h0000_0003);
      wr(FLG, ZERO);
      wr(FLG + 8'h08, ZERO);
      wr(CTL, ZERO);
      p.drive(24'h00_0201, 1'b0);
      out(change_irq, ZERO);
      rdc(FLG, ONE);
      rdc(STA, ZERO);
      rdc(CTL, ONE);
      wr(MSK, ONE);
      wr(CTL, 32'h0000_0008);
      p.drive(24'h00_0200, 1'b0);
      out(irq, ONE);
      wr(MSK, ZERO);
      out(irq, ZERO);
      wr(MSK, ONE);
      out(irq, ONE);
      wr(STA, ONE);
      out(irq, ZERO);
   endtask : t_irq
   task automatic t_sleep();
      // port 1 still holds the flag of the coincident-edge case
      wr(FLG + 8'h04, ZERO);
      wr(FLG, ZERO);
      p.drive(24'h00_0200, 1'b1);
      out(wake, ZERO);
      p.drive(24'h00_0201, 1'b1);
      out(wake, ONE);
      rdc(FLG, ONE);
      rdc(STA, 32'h0000_0003);
      wr(CTL, ZERO);
      wr(FLG, ZERO);
      p.drive(24'h00_0200, 1'b1);
      out(wake, ZERO);
      rdc(FLG, ONE);
   endtask : t_sleep
   task automatic t_all();
      wr(FALL, ZERO);
      wr(FALL + 8'h08, ZERO);
      p.drive(24'h00_0000, 1'b0);
      for (int i = 0; i < 3; i++)
      begin
         wr(RISE + 8'(4 * i), FF);
         wr(FLG + 8'(4 * i), ZERO);
      end
      p.drive(24'hff_ffff, 1'b0);
      for (int i = 0; i < 3; i++)
         rdc(FLG + 8'(4 * i), FF);
   endtask : t_all
   // reset, then the scenarios in turn
   initial
   begin
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      rdc(CTL, ZERO);
      rdc(RISE + 8'h08, ZERO);
      rdc(FALL + 8'h04, ZERO);
      rdc(FLG, ZERO);
      rdc(8'hf0, ZERO);
      t_dir();
      t_irq();
      t_sleep();
      t_all();
      wrap_up();
   end
endmodule : tb_top
